//--- hw/twd_defs.vh
`ifndef TWD_DEFS_VH
`define TWD_DEFS_VH

// register byte addresses
`define TWD_ADDR_CFG        8'h20
`define TWD_ADDR_PRESCALE   8'h22
`define TWD_ADDR_PRESET     8'h24
`define TWD_ADDR_CSR        8'h26
`define TWD_ADDR_WATCHDOG_RELOAD_COUNT      8'h28
`define TWD_ADDR_SERVICE    8'h2A

// watchdog_config_lock fields
`define TWD_CFG_LOCK_CFG    0
`define TWD_CFG_LOCK_PRE    1
`define TWD_CFG_LOCK_T0     2
`define TWD_CFG_LOCK_WD     3
`define TWD_CFG_WDCLK_SEL   4
`define TWD_CFG_MATCH_EN    5

// timer_zero_control_status fields
`define TWD_CSR_RESTART     0
`define TWD_CSR_TC          1
`define TWD_CSR_INTE        2
`define TWD_CSR_LTD         3
`define TWD_CSR_FRZ         4

// reset values and constants
`define TWD_PRESET_RST      16'hFFFF
`define TWD_WATCHDOG_RELOAD_COUNT_RST       8'h0F
`define TWD_SERVICE_MATCH   8'h5C

// timing
`define TWD_CLK_HZ          20000000
`define TWD_SLOW_HZ         32768
`define TWD_SLOW_DIV        (`TWD_CLK_HZ / `TWD_SLOW_HZ)
`define TWD_LTD_SLOW_CYCLES 5

`endif

//--- hw/twd_prescaler.v
`timescale 1ns/1ns
`include "twd_defs.vh"

module twd_prescaler #(
    parameter SLOW_DIV = `TWD_SLOW_DIV,
    parameter DIV_W    = 10
) (
    input  wire       clk_in,
    input  wire       rst_n_in,
    input  wire [2:0] prescale_select_in,
    output reg        slow_tick_out,
    output reg        tin_tick_out
);

    localparam integer DIV_LAST_I = SLOW_DIV - 1;
    localparam [DIV_W-1:0] DIV_LAST = DIV_LAST_I[DIV_W-1:0];

    reg [DIV_W-1:0] div_cnt;
    reg [4:0]       ps_cnt;
    wire [4:0]      mask;

    // reserved codes fall back to the slowest divisor
    function [4:0] div_mask;
        input [2:0] sel;
        begin
            case (sel)
                3'd0:    div_mask = 5'h00;
                3'd1:    div_mask = 5'h01;
                3'd2:    div_mask = 5'h03;
                3'd3:    div_mask = 5'h07;
                3'd4:    div_mask = 5'h0F;
                default: div_mask = 5'h1F;
            endcase
        end
    endfunction

    assign mask = div_mask(prescale_select_in);

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_cnt       <= {DIV_W{1'b0}};
            ps_cnt        <= 5'h00;
            slow_tick_out <= 1'b0;
            tin_tick_out  <= 1'b0;
        end else if (div_cnt == DIV_LAST) begin
            div_cnt       <= {DIV_W{1'b0}};
            ps_cnt        <= ps_cnt + 5'h01;
            slow_tick_out <= 1'b1;
            tin_tick_out  <= ((ps_cnt & mask) == mask);
        end else begin
            div_cnt       <= div_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
            slow_tick_out <= 1'b0;
            tin_tick_out  <= 1'b0;
        end
    end

endmodule

//--- hw/twd_top.v
// What this block does
// - three-bit prescaler divides slow clock by 1..32
// - timer zero reloads preset on every underflow
// - preset resets to all ones
// - freeze stops timer zero when enabled
// - first count write starts the watchdog
// - each count write restarts the countdown
// - watchdog count resets to 0Fh
// - match byte 5Ch reloads the watchdog
// - wrong match byte raises watchdog error
// - two services in one period error
// - service writes ignored when matching disabled
// - count sets allowed periods between services
// - any watchdog error resets the device
// - restart bit self-clears after actual restart
// - zero count pulses tick, sets terminal flag
// - select bit picks tick or prescaled clock
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
`include "twd_defs.vh"

module twd_top #(
    parameter SLOW_DIV = `TWD_SLOW_DIV,
    parameter LTD_CNT  = `TWD_LTD_SLOW_CYCLES
) (
    input  wire        clock_in,
    input  wire        arst_n_in,
    input  wire [7:0]  addr_in,
    input  wire [15:0] wr_data_in,
    input  wire        wr_in,
    input  wire        rd_in,
    input  wire        freeze_in,
    output reg  [15:0] rd_data_out,
    output reg         tick_out,
    output reg         irq_out,
    output reg         wd_reset_out
);

    // reset release
    reg rst_meta;
    reg rst_n;

    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // register state
    reg  [3:0]  lock;
    reg         watchdog_clock_select;
    reg         match_service_enable;
    reg  [2:0]  prescale_select;
    reg  [15:0] timer_zero_preset;
    reg         restart_req;
    reg         terminal_count_flag;
    reg         tick_interrupt_enable;
    reg         freeze_timer_enable;
    reg  [7:0]  watchdog_reload_count;

    // timer and watchdog state
    reg  [15:0] t0_cnt;
    reg         t0_tick_evt;
    reg         wd_run;
    reg  [7:0]  wd_cnt;
    reg         svc_seen;
    reg  [2:0]  ltd_cnt;
    wire        last_touch_delay;
    wire        slow_tick;
    wire        timer_input_clock;

    function hit;
        input [7:0] a;
        input [7:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    // one-hot register select, shared by the write and clear paths
    reg         sel_cfg;
    reg         sel_pre;
    reg         sel_pset;
    reg         sel_csr;
    reg         sel_wdc;
    reg         sel_svc;

    always @* begin
        sel_cfg  = 1'b0;
        sel_pre  = 1'b0;
        sel_pset = 1'b0;
        sel_csr  = 1'b0;
        sel_wdc  = 1'b0;
        sel_svc  = 1'b0;
        if (hit(addr_in, `TWD_ADDR_CFG)) begin
            sel_cfg = 1'b1;
        end else if (hit(addr_in, `TWD_ADDR_PRESCALE)) begin
            sel_pre = 1'b1;
        end else if (hit(addr_in, `TWD_ADDR_PRESET)) begin
            sel_pset = 1'b1;
        end else if (hit(addr_in, `TWD_ADDR_CSR)) begin
            sel_csr = 1'b1;
        end else if (hit(addr_in, `TWD_ADDR_WATCHDOG_RELOAD_COUNT)) begin
            sel_wdc = 1'b1;
        end else if (hit(addr_in, `TWD_ADDR_SERVICE)) begin
            sel_svc = 1'b1;
        end
    end

    wire wr_cfg  = wr_in && sel_cfg && !lock[`TWD_CFG_LOCK_CFG];
    wire wr_pre  = wr_in && sel_pre && !lock[`TWD_CFG_LOCK_PRE];
    wire wr_pset = wr_in && sel_pset && !lock[`TWD_CFG_LOCK_T0];
    wire wr_csr  = wr_in && sel_csr && !lock[`TWD_CFG_LOCK_T0];
    wire wr_wdc  = wr_in && sel_wdc && !lock[`TWD_CFG_LOCK_WD];
    wire wr_svc  = wr_in && sel_svc;
    wire rd_csr  = rd_in && sel_csr && !lock[`TWD_CFG_LOCK_T0];

    twd_prescaler #(
        .SLOW_DIV (SLOW_DIV)
    ) u_prescaler (
        .clk_in             (clock_in),
        .rst_n_in           (rst_n),
        .prescale_select_in (prescale_select),
        .slow_tick_out      (slow_tick),
        .tin_tick_out       (timer_input_clock)
    );

    // configuration: lock bits only ever accumulate until reset
    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            lock                  <= 4'h0;
            watchdog_clock_select <= 1'b0;
            match_service_enable  <= 1'b0;
        end else if (wr_cfg) begin
            lock                  <= lock | wr_data_in[3:0];
            watchdog_clock_select <= wr_data_in[`TWD_CFG_WDCLK_SEL];
            match_service_enable  <= wr_data_in[`TWD_CFG_MATCH_EN];
        end
    end

    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            prescale_select <= 3'h0;
        end else if (wr_pre) begin
            prescale_select <= wr_data_in[2:0];
        end
    end

    // a new preset takes effect only at the next reload
    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            timer_zero_preset <= `TWD_PRESET_RST;
        end else if (wr_pset) begin
            timer_zero_preset <= wr_data_in;
        end
    end

    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            tick_interrupt_enable <= 1'b0;
            freeze_timer_enable   <= 1'b0;
        end else if (wr_csr) begin
            tick_interrupt_enable <= wr_data_in[`TWD_CSR_INTE];
            freeze_timer_enable   <= wr_data_in[`TWD_CSR_FRZ];
        end
    end

    // timer zero
    wire t0_run  = !(freeze_in && freeze_timer_enable);
    wire t0_step = timer_input_clock && t0_run;

    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            t0_cnt      <= `TWD_PRESET_RST;
            tick_out    <= 1'b0;
            t0_tick_evt <= 1'b0;
        end else begin
            t0_tick_evt <= 1'b0;
            if (t0_step) begin
                if (restart_req) begin
                    t0_cnt   <= timer_zero_preset;
                    tick_out <= 1'b0;
                end else if (t0_cnt == 16'h0001) begin
                    t0_cnt      <= 16'h0000;
                    tick_out    <= 1'b1;
                    t0_tick_evt <= 1'b1;
                end else if (t0_cnt == 16'h0000) begin
                    t0_cnt   <= timer_zero_preset;
                    tick_out <= 1'b0;
                end else begin
                    t0_cnt   <= t0_cnt - 16'h0001;
                    tick_out <= 1'b0;
                end
            end
        end
    end

    // a fresh request wins over the self-clear in the same cycle
    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            restart_req <= 1'b0;
        end else if (wr_csr && wr_data_in[`TWD_CSR_RESTART]) begin
            restart_req <= 1'b1;
        end else if (t0_step && restart_req) begin
            restart_req <= 1'b0;
        end
    end

    // set beats the read-clear; writes to the flag are ignored
    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            terminal_count_flag <= 1'b0;
        end else if (t0_tick_evt) begin
            terminal_count_flag <= 1'b1;
        end else if (rd_csr) begin
            terminal_count_flag <= 1'b0;
        end
    end

    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= t0_tick_evt && tick_interrupt_enable;
        end
    end

    // watchdog always halts in freeze, whatever the timer does
    wire wd_src  = watchdog_clock_select ? timer_input_clock : t0_tick_evt;
    wire wd_evt  = wd_src && !freeze_in && wd_run;
    wire svc_ok  = wr_svc && match_service_enable
                   && (wr_data_in[7:0] == `TWD_SERVICE_MATCH) && !svc_seen;
    wire svc_bad = wr_svc && match_service_enable
                   && ((wr_data_in[7:0] != `TWD_SERVICE_MATCH) || svc_seen);

    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_reload_count <= `TWD_WATCHDOG_RELOAD_COUNT_RST;
        end else if (wr_wdc) begin
            watchdog_reload_count <= wr_data_in[7:0];
        end
    end

    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            wd_run   <= 1'b0;
            wd_cnt   <= `TWD_WATCHDOG_RELOAD_COUNT_RST;
            svc_seen <= 1'b0;
        end else if (wr_wdc) begin
            wd_run   <= 1'b1;
            wd_cnt   <= wr_data_in[7:0];
            svc_seen <= 1'b0;
        end else if (svc_ok) begin
            wd_run   <= 1'b1;
            wd_cnt   <= watchdog_reload_count;
            svc_seen <= 1'b1;
        end else if (wd_evt) begin
            svc_seen <= 1'b0;
            if (wd_cnt != 8'h00) begin
                wd_cnt <= wd_cnt - 8'h01;
            end
        end
    end

    // the error is held; the whole device, this block included, resets
    wire wd_late = wd_evt && !wr_wdc && !svc_ok && (wd_cnt == 8'h00);

    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            wd_reset_out <= 1'b0;
        end else if (wd_late || svc_bad) begin
            wd_reset_out <= 1'b1;
        end
    end
    // service writes with matching disabled fall through every branch above

    // delay flag spans a few slow-clock periods after a watchdog write
    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ltd_cnt <= 3'h0;
        end else if (wr_wdc || (wr_svc && match_service_enable)) begin
            ltd_cnt <= LTD_CNT[2:0];
        end else if (slow_tick && (ltd_cnt != 3'h0)) begin
            ltd_cnt <= ltd_cnt - 3'h1;
        end
    end

    assign last_touch_delay = (ltd_cnt != 3'h0);

    // read port; locked and write-only registers read zero
    reg [15:0] next_rd_data;

    always @* begin
        next_rd_data = 16'h0000;
        if (!rd_in) begin
            next_rd_data = 16'h0000;
        end else if (hit(addr_in, `TWD_ADDR_CFG)) begin
            if (!lock[`TWD_CFG_LOCK_CFG]) begin
                next_rd_data = {10'h000, match_service_enable,
                                watchdog_clock_select, lock};
            end
        end else if (hit(addr_in, `TWD_ADDR_PRESCALE)) begin
            if (!lock[`TWD_CFG_LOCK_PRE]) begin
                next_rd_data = {13'h0000, prescale_select};
            end
        end else if (hit(addr_in, `TWD_ADDR_PRESET)) begin
            if (!lock[`TWD_CFG_LOCK_T0]) begin
                next_rd_data = timer_zero_preset;
            end
        end else if (hit(addr_in, `TWD_ADDR_CSR)) begin
            if (!lock[`TWD_CFG_LOCK_T0]) begin
                next_rd_data = {11'h000, freeze_timer_enable, last_touch_delay,
                                tick_interrupt_enable, terminal_count_flag,
                                restart_req};
            end
        end
    end

    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_out <= 16'h0000;
        end else begin
            rd_data_out <= next_rd_data;
        end
    end

endmodule

//--- bench/twd_chk.sv
`timescale 1ns/1ns
`include "twd_defs.vh"
module twd_chk #(
    parameter SLOW_DIV = 4,
    parameter LTD_CNT  = 5
) (
    input wire        clock_in,
    input wire        arst_n_in,
    input wire [7:0]  addr_in,
    input wire [15:0] wr_data_in,
    input wire        wr_in,
    input wire        rd_in,
    input wire        freeze_in,
    input wire [15:0] rd_data_out,
    input wire        tick_out,
    input wire        irq_out,
    input wire        wd_reset_out
);
    reg  started;
    reg  frz_en;
    reg  match_en;
    reg  cfg_lock;
    wire wd_wr = wr_in && (addr_in == `TWD_ADDR_WATCHDOG_RELOAD_COUNT || addr_in == `TWD_ADDR_SERVICE);
    wire svc_bad = wr_in && addr_in == `TWD_ADDR_SERVICE && wr_data_in[7:0] != 8'h5c;
    // shadow copies: the checker cannot read control bits back
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            started  <= 1'h0;
            frz_en   <= 1'h0;
            match_en <= 1'h0;
            cfg_lock <= 1'h0;
        end else begin
            if (wd_wr) begin
                started <= 1'h1;
            end
            if (wr_in && addr_in == `TWD_ADDR_CSR) begin
                frz_en <= wr_data_in[4];
            end
            if (wr_in && addr_in == `TWD_ADDR_CFG && !cfg_lock) begin
                match_en <= wr_data_in[5];
                cfg_lock <= wr_data_in[0];
            end
        end
    end
    default clocking dcb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    rd_idle_zero_a: assert property (!rd_in |=> rd_data_out == 16'h0000)
        else $error("read data not zero outside a read");
    wo_read_zero_a: assert property (rd_in && wd_wr == 1'h0 &&
        (addr_in == `TWD_ADDR_WATCHDOG_RELOAD_COUNT || addr_in == `TWD_ADDR_SERVICE) |=> rd_data_out == 16'h0000)
        else $error("write-only register read back nonzero");
    wd_quiet_a: assert property (!started && !wd_wr |=> !wd_reset_out)
        else $error("watchdog error before it was started");
    wd_sticky_a: assert property (wd_reset_out |=> wd_reset_out)
        else $error("watchdog reset dropped without reset");
    irq_pulse_a: assert property (irq_out |=> !irq_out)
        else $error("interrupt longer than one cycle");
    irq_tick_a: assert property (irq_out |-> tick_out && $past(tick_out))
        else $error("interrupt not tied to tick rise");
    tick_width_a: assert property ($rose(tick_out) |=> tick_out [*3])
        else $error("tick shorter than one input period");
    tick_gap_a: assert property ($rose(tick_out) |=> !$rose(tick_out) [*3])
        else $error("ticks closer than one input period");
    freeze_hold_a: assert property ((frz_en && freeze_in) [*4] |-> $stable(tick_out))
        else $error("tick moved while frozen");
    bad_byte_a: assert property (svc_bad && match_en |-> ##[1:3] wd_reset_out)
        else $error("wrong service byte gave no error");
    irq_c: cover property (irq_out);
    wd_err_c: cover property ($rose(wd_reset_out));
    frozen_c: cover property (frz_en && freeze_in);
endmodule
bind twd_top twd_chk #(.SLOW_DIV(SLOW_DIV), .LTD_CNT(LTD_CNT)) u_twd_chk (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .freeze_in(freeze_in), .rd_data_out(rd_data_out),
    .tick_out(tick_out), .irq_out(irq_out), .wd_reset_out(wd_reset_out));

//--- bench/test_twd_top.sv
`timescale 1ns/1ns
`include "twd_defs.vh"
module test_twd_top;
    localparam int SLOW = 4;
    logic        clock_in = 1'h0;
    logic        arst_n_in = 1'h0;
    logic [7:0]  addr_in = 8'h00;
    logic [15:0] wr_data_in = 16'h0000;
    logic        wr_in = 1'h0;
    logic        rd_in = 1'h0;
    logic        freeze_in = 1'h0;
    logic [15:0] rd_data_out;
    logic        tick_out;
    logic        irq_out;
    logic        wd_reset_out;
    logic        tick_q = 1'h0;
    int          fails = 0;
    int          comparisons = 0;
    int          irqs = 0;
    int          rises = 0;
    twd_top #(.SLOW_DIV(SLOW), .LTD_CNT(5)) u_twd_top (
        .clock_in(clock_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_in(wr_in), .rd_in(rd_in), .freeze_in(freeze_in), .rd_data_out(rd_data_out),
        .tick_out(tick_out), .irq_out(irq_out), .wd_reset_out(wd_reset_out));
    always #25 clock_in = ~clock_in;
    always @(negedge clock_in) begin
        if (irq_out === 1'h1) irqs++;
        if (tick_out === 1'h1 && tick_q !== 1'h1) rises++;
        tick_q = tick_out;
    end
    task automatic test_done;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", w, e, g);
            fails++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'h1;
        @(posedge clock_in);
        wr_in <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e,
                      input string w);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'h1;
        @(posedge clock_in);
        rd_in <= 1'h0;
        @(negedge clock_in);
        chk(w, e, rd_data_out & m);
    endtask
    task automatic do_reset;
        @(posedge clock_in);
        arst_n_in <= 1'h0;
        repeat (16) @(posedge clock_in);
        arst_n_in <= 1'h1;
        repeat (3) @(posedge clock_in);
    endtask
    task automatic rise_gap(output int cyc);
        logic p;
        p = tick_out;
        for (cyc = 1; cyc < 6000; cyc++) begin
            @(negedge clock_in);
            if (tick_out === 1'h1 && p !== 1'h1) return;
            p = tick_out;
        end
        fails++;
        test_done();
    endtask
    // error must stay away for lo cycles and show by hi
    task automatic wd_window(input int lo, input int hi);
        int i;
        for (i = 1; i <= hi; i++) begin
            @(negedge clock_in);
            if (wd_reset_out === 1'h1) break;
        end
        chk("wd_reset_time", 16'h0001, {15'h0000, i > lo && i <= hi});
        if (i > hi) test_done();
    endtask
    // model of the tick period: (preset+1) input periods, reserved codes divide by 32
    function automatic int period(int sel, int p);
        return (p + 1) * (sel > 5 ? 32 : (1 << sel)) * SLOW;
    endfunction
    initial begin
        int p, n, g, s, k;
        void'($urandom(32'hf3ca));
        do_reset();
        rd(`TWD_ADDR_PRESET, 16'hffff, 16'hffff, "preset_reset");
        rd(`TWD_ADDR_CSR, 16'hffff, 16'h0000, "csr_reset");
        rd(`TWD_ADDR_WATCHDOG_RELOAD_COUNT, 16'hffff, 16'h0000, "watchdog_reload_count_read");
        rd(8'h30, 16'hffff, 16'h0000, "unmapped_read");
        for (s = 0; s < 7; s++) begin
            p = $urandom_range(3, 1);
            wr(`TWD_ADDR_PRESCALE, s[15:0]);
            wr(`TWD_ADDR_PRESET, p[15:0]);
            wr(`TWD_ADDR_CSR, 16'h0005);
            rise_gap(g);
            rise_gap(g);
            k = period(s, p);
            chk("tick_period", k[15:0], g[15:0]);
            rd(`TWD_ADDR_CSR, 16'hffff, 16'h0006, "csr_after_tick");
            rd(`TWD_ADDR_CSR, 16'h0002, 16'h0000, "tc_cleared");
        end
        chk("irq_seen", 16'h0001, {15'h0000, irqs > 0});
        wr(`TWD_ADDR_PRESCALE, 16'h0000);
        wr(`TWD_ADDR_PRESET, 16'h0001);
        wr(`TWD_ADDR_CSR, 16'h0011);
        freeze_in <= 1'h1;
        repeat (6) @(posedge clock_in);
        rises = 0;
        repeat (100) @(posedge clock_in);
        chk("frozen_ticks", 16'h0000, rises[15:0]);
        wr(`TWD_ADDR_CSR, 16'h0000);
        rises = 0;
        irqs = 0;
        repeat (100) @(posedge clock_in);
        chk("running_ticks", 16'h0001, {15'h0000, rises >= 100 / (2 * SLOW) - 1});
        chk("masked_irq", 16'h0000, irqs[15:0]);
        freeze_in <= 1'h0;
        chk("wd_not_started", 16'h0000, {15'h0000, wd_reset_out});
        n = $urandom_range(6, 3);
        wr(`TWD_ADDR_CFG, 16'h0010);
        wr(`TWD_ADDR_WATCHDOG_RELOAD_COUNT, n[15:0]);
        rd(`TWD_ADDR_CSR, 16'h0008, 16'h0008, "ltd_busy");
        for (k = 0; k < 4; k++) begin
            repeat (4 * n - 6) @(posedge clock_in);
            wr(`TWD_ADDR_WATCHDOG_RELOAD_COUNT, n[15:0]);
        end
        wr(`TWD_ADDR_SERVICE, 16'h0000);
        wd_window(4 * n - 3, 4 * n + 6);
        do_reset();
        wr(`TWD_ADDR_PRESCALE, 16'h0000);
        wr(`TWD_ADDR_PRESET, 16'h0001);
        wr(`TWD_ADDR_CFG, 16'h0010);
        wr(`TWD_ADDR_WATCHDOG_RELOAD_COUNT, n[15:0]);
        wr(`TWD_ADDR_CSR, 16'h0001);
        wr(`TWD_ADDR_CFG, 16'h003f);
        for (k = 0; k < 4; k++) begin
            repeat (4 * n - 6) @(posedge clock_in);
            wr(`TWD_ADDR_SERVICE, 16'h005c);
        end
        chk("served_no_error", 16'h0000, {15'h0000, wd_reset_out});
        wr(`TWD_ADDR_SERVICE, 16'h005d);
        wd_window(0, 4);
        do_reset();
        wr(`TWD_ADDR_PRESCALE, 16'h0002);
        wr(`TWD_ADDR_PRESET, 16'h0003);
        wr(`TWD_ADDR_CFG, 16'h0020);
        wr(`TWD_ADDR_WATCHDOG_RELOAD_COUNT, 16'h0020);
        wr(`TWD_ADDR_CSR, 16'h0001);
        repeat (20) @(posedge clock_in);
        // three services so that two surely share one slow watchdog period
        for (k = 0; k < 3; k++) wr(`TWD_ADDR_SERVICE, 16'h005c);
        wd_window(0, 8);
        do_reset();
        chk("wd_after_reset", 16'h0000, {15'h0000, wd_reset_out});
        // a service as first touch starts the count from the reset value 0Fh
        wr(`TWD_ADDR_CFG, 16'h0030);
        wr(`TWD_ADDR_SERVICE, 16'h005c);
        wd_window(56, 70);
        test_done();
    end
endmodule
